// file: rtl/pahi_pkg.sv
// Purpose: Shared constants for the parallel converter host port.
// Assumes: 200 MHz system clock; all pins synchronised before use.
// Notes:   Control register field positions are local choices.
package pahi_pkg;
    // System clock period in picoseconds
    localparam int unsigned CLK_PERIOD_PS  = 5000;
    // Data bus and control register widths
    localparam int unsigned DATA_W         = 12;
    localparam int unsigned BYTE_W         = 8;
    localparam int unsigned CHAN_W         = 2;
    // Master clock rising edges in one conversion
    localparam logic [3:0]  CONV_EDGES     = 4'hD;
    // Fixed tail of the conversion after the last master clock edge, in ns
    localparam int unsigned CONV_TAIL_NS   = 60;
    localparam int unsigned CONV_TAIL_CYC  = (CONV_TAIL_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    // Control register layout and reset value
    localparam int unsigned CTRL_CHAN_LSB  = 0;
    localparam int unsigned CTRL_PM_LSB    = 2;
    localparam logic [11:0] CTRL_RESET     = 12'h000;
    // High-byte read layout
    localparam int unsigned HB_CHAN_LSB    = 4;
    localparam int unsigned HB_DATA_W      = 4;

    // Power management modes held in the control register
    typedef enum logic [1:0] {
        PAHI_PM_NORMAL   = 2'h0,
        PAHI_PM_FULL_OFF = 2'h1,
        PAHI_PM_AUTO_OFF = 2'h2,
        PAHI_PM_AUTO_SBY = 2'h3
    } pahi_pm_t;
endpackage : pahi_pkg

// file: rtl/pahi_sync.sv
// Purpose: Two-flop synchroniser for a group of asynchronous pins.
// Assumes: Inputs are quasi-static relative to the clock.
// Notes:   The first stage feeds only the second stage.
module pahi_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             clock,   // System clock
    input  wire logic             reset,   // Synchronous reset, active high
    input  wire logic [WIDTH-1:0] async_i, // Asynchronous pins
    output logic      [WIDTH-1:0] sync_o   // Synchronised copy
);
    logic [WIDTH-1:0] meta_q;

    // Two stages of retiming
    always_ff @(posedge clock) begin
        if (reset) begin
            meta_q <= INIT;
            sync_o <= INIT;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end
endmodule : pahi_sync

// file: rtl/pahi_port.sv
// Purpose: Host port of a four-channel converter: conversion timing and parallel bus.
// Assumes: Analog core presents its code on core_code when conversion ends.
// Notes:   All pins pass two flops; master_clock_in is sampled, not used as a clock.
// What this block does
// - Word mode moves full twelve-bit words on all data pins.
// - Byte mode uses eight low pins; pin eight becomes high byte enable.
// - Byte mode, high byte enable low: low byte on low pins.
// - Byte mode, high byte enable high: top four bits on lowest pins.
// - High-byte read carries channel tag in bits four and five.
// - High-byte read drives bits six and seven as zero.
// - Data pins are three-state, gated by chip select, read and write.
// - Word mode: shared pin acts as data bit eight.
// - Busy rises after convert start falls, stays high through conversion.
// - Busy falls on the same clock edge that loads result into output register.
// - Sampler returns to track on thirteenth master clock rise.
// - Conversion is thirteen master clocks plus a fixed tail.
// - Master clock may run freely or only in bursts.
// - Convert start falling edge holds sample and starts conversion.
// - In automatic power-down modes, convert start rising edge powers up.
// - Write strobe with chip select low stores data into control register.
// - Read strobe with chip select low drives the result onto pins.
// - Channel comes from control register address bits before conversion.
module pahi_port
    import pahi_pkg::*;
#(
    parameter int unsigned TAIL_CYC = pahi_pkg::CONV_TAIL_CYC
) (
    input  wire logic                        clock,             // System clock, 200 MHz
    input  wire logic                        reset,             // Synchronous reset, active high
    input  wire logic                        master_clock_in,   // Conversion clock pin
    input  wire logic                        convert_start_n,   // Conversion start pin, active low
    input  wire logic                        chip_select_n,     // Chip select pin, active low
    input  wire logic                        read_strobe_n,     // Read strobe pin, active low
    input  wire logic                        write_strobe_n,    // Write strobe pin, active low
    input  wire logic                        word_byte_select,  // High selects word mode
    input  wire logic [pahi_pkg::DATA_W-1:0] data_in,           // Data pins, input side
    output logic      [pahi_pkg::DATA_W-1:0] data_out,          // Data pins, output side
    output logic      [pahi_pkg::DATA_W-1:0] data_oe,           // Data pins, output enable
    input  wire logic [pahi_pkg::DATA_W-1:0] core_code,         // Code from analog core
    output logic                             busy,              // Conversion in progress
    output logic                             hold_mode,         // Sampler in hold
    output logic                             powered_up,        // Core powered
    output logic      [pahi_pkg::CHAN_W-1:0] active_channel,    // Channel being converted
    output logic      [pahi_pkg::DATA_W-1:0] control_value      // Control register contents
);
    import pahi_pkg::*;

    typedef enum logic [1:0] {
        PAHI_IDLE,
        PAHI_CONVERT,
        PAHI_TAIL
    } pahi_state_t;

    localparam int unsigned PIN_W = 6 + DATA_W;

    logic [PIN_W-1:0]  pins_s;
    logic              mclk_s, conv_n_s, cs_n_s, rd_n_s, wr_n_s, wb_s;
    logic [DATA_W-1:0] din_s;
    logic              mclk_prev_q, conv_prev_q, rd_prev_q, wr_prev_q;
    pahi_state_t       state_q;
    logic [3:0]        edge_cnt_q;
    logic [15:0]       tail_cnt_q;
    logic [DATA_W-1:0] ctrl_q;
    logic [DATA_W-1:0] result_q;
    logic [CHAN_W-1:0] result_chan_q;
    logic              down_q;
    logic              mclk_rise, conv_fall, conv_rise, rd_fall, wr_rise;
    logic              high_byte_enable, read_active;
    pahi_pm_t          pm_mode;

    // Every pin passes two flops before use
    pahi_sync #(
        .WIDTH (PIN_W),
        .INIT  ({6'h1E, {DATA_W{1'b0}}})
    ) u_sync (
        .clock   (clock),
        .reset   (reset),
        .async_i ({master_clock_in, convert_start_n, chip_select_n, read_strobe_n,
                   write_strobe_n, word_byte_select, data_in}),
        .sync_o  (pins_s)
    );

    assign {mclk_s, conv_n_s, cs_n_s, rd_n_s, wr_n_s, wb_s, din_s} = pins_s;
    assign high_byte_enable    = din_s[BYTE_W];
    assign pm_mode = pahi_pm_t'(ctrl_q[CTRL_PM_LSB +: 2]);

    // Previous values for edge detection on synchronised pins
    always_ff @(posedge clock) begin
        if (reset) begin
            mclk_prev_q <= 1'b0;
            conv_prev_q <= 1'b1;
            rd_prev_q   <= 1'b1;
            wr_prev_q   <= 1'b1;
        end else begin
            mclk_prev_q <= mclk_s;
            conv_prev_q <= conv_n_s;
            rd_prev_q   <= rd_n_s;
            wr_prev_q   <= wr_n_s;
        end
    end

    // Edges; master clock edges are counted only when present
    assign mclk_rise = mclk_s & ~mclk_prev_q;
    assign conv_fall = conv_prev_q & ~conv_n_s;
    assign conv_rise = ~conv_prev_q & conv_n_s;
    assign rd_fall   = rd_prev_q & ~rd_n_s;
    assign wr_rise   = ~wr_prev_q & wr_n_s;

    // Conversion sequence
    always_ff @(posedge clock) begin
        if (reset) begin
            state_q    <= PAHI_IDLE;
            edge_cnt_q <= 4'h0;
            tail_cnt_q <= 16'h0000;
        end else begin
            unique case (state_q)
                PAHI_IDLE: begin
                    if (conv_fall && !down_q) begin
                        state_q    <= PAHI_CONVERT;
                        edge_cnt_q <= 4'h0;
                    end
                end
                PAHI_CONVERT: begin
                    if (mclk_rise) begin
                        edge_cnt_q <= edge_cnt_q + 4'h1;
                        if (edge_cnt_q == CONV_EDGES - 4'h1) begin
                            state_q    <= PAHI_TAIL;
                            tail_cnt_q <= 16'h0000;
                        end
                    end
                end
                PAHI_TAIL: begin
                    tail_cnt_q <= tail_cnt_q + 16'h0001;
                    if (tail_cnt_q >= 16'(TAIL_CYC) - 16'h0001) begin
                        state_q <= PAHI_IDLE;
                    end
                end
            endcase
        end
    end

    // Busy and sampler state follow the sequence
    always_ff @(posedge clock) begin
        if (reset) begin
            busy      <= 1'b0;
            hold_mode <= 1'b0;
        end else begin
            if (state_q == PAHI_IDLE && conv_fall && !down_q) begin
                busy      <= 1'b1;
                hold_mode <= 1'b1;
            end else if (state_q == PAHI_CONVERT && mclk_rise && edge_cnt_q == CONV_EDGES - 4'h1) begin
                hold_mode <= 1'b0;
            end else if (state_q == PAHI_TAIL && tail_cnt_q >= 16'(TAIL_CYC) - 16'h0001) begin
                busy      <= 1'b0;
            end
        end
    end

    // Channel is latched from the control register when conversion starts
    always_ff @(posedge clock) begin
        if (reset) begin
            active_channel <= '0;
        end else if (state_q == PAHI_IDLE && conv_fall && !down_q) begin
            active_channel <= ctrl_q[CTRL_CHAN_LSB +: CHAN_W];
        end
    end

    // Output register: loaded at end of conversion, kept otherwise
    always_ff @(posedge clock) begin
        if (reset) begin
            result_q      <= '0;
            result_chan_q <= '0;
        end else if (state_q == PAHI_TAIL && tail_cnt_q >= 16'(TAIL_CYC) - 16'h0001) begin
            result_q      <= core_code;
            result_chan_q <= active_channel;
        end
    end

    // Power state: automatic modes sleep after a conversion, wake on rising start
    always_ff @(posedge clock) begin
        if (reset) begin
            down_q <= 1'b0;
        end else if (pm_mode == PAHI_PM_FULL_OFF) begin
            down_q <= 1'b1;
        end else if (pm_mode == PAHI_PM_NORMAL) begin
            down_q <= 1'b0;
        end else if (down_q && conv_rise) begin
            down_q <= 1'b0;
        end else if (state_q == PAHI_TAIL && tail_cnt_q >= 16'(TAIL_CYC) - 16'h0001) begin
            down_q <= 1'b1;
        end
    end

    assign powered_up = ~down_q;

    // Control register write at the end of a write strobe under chip select
    always_ff @(posedge clock) begin
        if (reset) begin
            ctrl_q <= CTRL_RESET;
        end else if (wr_rise && !cs_n_s) begin
            if (wb_s) begin
                ctrl_q <= din_s;
            end else if (!high_byte_enable) begin
                ctrl_q[BYTE_W-1:0] <= din_s[BYTE_W-1:0];
            end else begin
                ctrl_q[DATA_W-1:BYTE_W] <= din_s[HB_DATA_W-1:0];
            end
        end
    end

    assign control_value = ctrl_q;

    // Read data formatted on the strobe's falling edge
    always_ff @(posedge clock) begin
        if (reset) begin
            data_out <= '0;
        end else if (rd_fall && !cs_n_s) begin
            if (wb_s) begin
                data_out <= result_q;
            end else if (!high_byte_enable) begin
                data_out <= {{(DATA_W-BYTE_W){1'b0}}, result_q[BYTE_W-1:0]};
            end else begin
                data_out <= {{(DATA_W-BYTE_W){1'b0}}, 2'b00, result_chan_q,
                             result_q[DATA_W-1:BYTE_W]};
            end
        end
    end

    // Drive while read and chip select stay low, after data are ready
    always_ff @(posedge clock) begin
        if (reset) begin
            read_active <= 1'b0;
        end else begin
            read_active <= !cs_n_s && !rd_n_s && wr_n_s;
        end
    end

    // Enables per pin: byte mode frees pins eight to eleven
    always_comb begin
        data_oe = '0;
        if (read_active) begin
            data_oe[BYTE_W-1:0] = '1;
            if (wb_s) begin
                data_oe = '1;
            end
        end
    end
endmodule : pahi_port

// file: test/pahi_port_properties.sv
// Purpose: Concurrent checks on the converter host port pins.
// Assumes: Host holds each pin level for several clocks.
// Notes:   Bound into pahi_port from the bench top.
module pahi_port_properties
    import pahi_pkg::*;
#(
    parameter int unsigned TAIL_CYC = 12
) (
    input wire logic                        clock,            // System clock
    input wire logic                        reset,            // Synchronous reset
    input wire logic                        convert_start_n,  // Conversion start pin
    input wire logic                        chip_select_n,    // Chip select pin
    input wire logic                        read_strobe_n,    // Read strobe pin
    input wire logic                        word_byte_select, // Word mode select
    input wire logic [pahi_pkg::DATA_W-1:0] data_in,          // Data pins in
    input wire logic [pahi_pkg::DATA_W-1:0] data_out,         // Data pins out
    input wire logic [pahi_pkg::DATA_W-1:0] data_oe,          // Data pin enables
    input wire logic                        busy,             // Conversion busy
    input wire logic                        hold_mode,        // Sampler hold
    input wire logic [pahi_pkg::CHAN_W-1:0] active_channel,   // Converted channel
    input wire logic [pahi_pkg::DATA_W-1:0] control_value     // Control register
);
    timeunit 1ns;
    timeprecision 1ps;
    // One clock domain for every check
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);
    chk_oe_idle_bus: assert property ((read_strobe_n || chip_select_n) [*6] |-> data_oe == 12'h000)
        else $error("data pins driven without a read");
    chk_byte_pins_only: assert property (!word_byte_select && !$past(word_byte_select, 5) |-> data_oe[11:8] == 4'h0)
        else $error("upper pins driven in byte mode");
    chk_word_pins_all: assert property (data_oe != 12'h000 && word_byte_select && $past(word_byte_select, 5) |-> data_oe == 12'hFFF)
        else $error("word read not on all pins");
    chk_high_byte_zero: assert property (data_oe[0] && !word_byte_select && data_in[8] && $past(data_in[8], 4) |-> data_out[7:6] == 2'h0)
        else $error("high byte top bits not zero");
    chk_busy_start: assert property ($fell(convert_start_n) && !busy && control_value[3:2] == 2'h0 |-> ##[2:4] (busy && hold_mode))
        else $error("conversion did not start");
    chk_hold_in_busy: assert property (hold_mode |-> busy)
        else $error("hold outside busy");
    chk_busy_tail_len: assert property ($fell(hold_mode) |-> busy ##TAIL_CYC $fell(busy))
        else $error("busy tail length wrong");
    chk_chan_steady: assert property (busy && $past(busy) |-> $stable(active_channel))
        else $error("channel changed in conversion");
    // Main scenarios seen
    cov_conversion: cover property ($fell(busy));
    cov_word_read: cover property (data_oe == 12'hFFF);
    cov_byte_read: cover property (data_oe == 12'h0FF);
endmodule : pahi_port_properties

// file: test/pahi_core_model.sv
// Purpose: Analog core stand-in feeding the conversion code.
// Assumes: Code is only meaningful while busy.
// Notes:   Outside a conversion the code toggles to expose early sampling.
module pahi_core_model (
    input  wire logic        clock,          // System clock
    input  wire logic        busy,           // Conversion busy
    input  wire logic [1:0]  active_channel, // Channel being converted
    output logic      [11:0] core_code       // Code to the port
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] junk_q;
    // Junk pattern changes every cycle
    always @(posedge clock) begin
        junk_q <= ~junk_q;
    end
    initial junk_q = 12'hA5A;
    // Code per channel during conversion
    assign core_code = busy ? (12'h5C3 ^ {6{active_channel}}) : junk_q;
endmodule : pahi_core_model

// file: test/tb_top.sv
// Purpose: Self-checking bench for the converter host port.
// Assumes: Host pins change right after rising edges.
// Notes:   Short conversion tail of four cycles.
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 0, reset = 1, master_clock_in = 0, convert_start_n = 1;
    logic        chip_select_n = 1, read_strobe_n = 1, write_strobe_n = 1, word_byte_select = 1;
    logic [11:0] host_val = 12'h000, host_en = 12'h000, idle_pat = 12'hA5A;
    logic [11:0] data_in, data_out, data_oe, core_code, control_value;
    logic        busy, hold_mode, powered_up;
    logic [1:0]  active_channel;
    int          n_mismatch = 0, comparisons = 0;
    // Clock at 200 MHz and a changing pattern on released lines
    always #2.5 clock = ~clock;
    always @(posedge clock) idle_pat <= ~idle_pat;
    assign data_in = (data_oe & data_out) | (~data_oe & host_en & host_val) | (~data_oe & ~host_en & idle_pat);
    pahi_port #(.TAIL_CYC(4)) dut (.clock(clock), .reset(reset), .master_clock_in(master_clock_in),
        .convert_start_n(convert_start_n), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
        .write_strobe_n(write_strobe_n), .word_byte_select(word_byte_select), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .core_code(core_code), .busy(busy), .hold_mode(hold_mode),
        .powered_up(powered_up), .active_channel(active_channel), .control_value(control_value));
    pahi_core_model u_core (.clock(clock), .busy(busy), .active_channel(active_channel), .core_code(core_code));
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
    endtask : cyc
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Host write: strobe edge commits while chip select low
    task automatic bus_write(input logic [11:0] pins, input logic sel_n);
        chip_select_n <= sel_n;
        host_en <= 12'hFFF;
        host_val <= pins;
        cyc(1);
        write_strobe_n <= 0;
        cyc(5);
        write_strobe_n <= 1;
        cyc(4);
        chip_select_n <= 1;
        host_en <= word_byte_select ? 12'h000 : 12'hF00;
        cyc(4);
    endtask : bus_write
    // Host read of one word or byte, judged on pins and enables
    task automatic bus_read(input logic hb, input logic [11:0] exp, input logic [11:0] mask);
        host_val <= {3'h0, hb, 8'h00};
        host_en <= word_byte_select ? 12'h000 : 12'hF00;
        cyc(4);
        chip_select_n <= 0;
        read_strobe_n <= 0;
        cyc(6);
        check(data_out & mask, exp);
        check(data_oe, mask);
        chip_select_n <= 1;
        read_strobe_n <= 1;
        cyc(6);
    endtask : bus_read
    // One conversion with the given control word, then all read forms
    task automatic conv(input logic [11:0] ctrl);
        logic [11:0] code;
        code = 12'h5C3 ^ {6{ctrl[1:0]}};
        bus_write(ctrl, 0);
        convert_start_n <= 0;
        cyc(5);
        check({10'h000, busy, hold_mode}, 12'h003);
        check({10'h000, active_channel}, {10'h000, ctrl[1:0]});
        convert_start_n <= 1;
        repeat (12) begin
            cyc(4); master_clock_in <= 1; cyc(4); master_clock_in <= 0;
        end
        check({10'h000, busy, hold_mode}, 12'h003);
        cyc(4); master_clock_in <= 1; cyc(4); master_clock_in <= 0;
        check({10'h000, busy, hold_mode}, 12'h002);
        cyc(4);
        check({10'h000, busy, hold_mode}, 12'h000);
        bus_read(0, code, 12'hFFF);
        word_byte_select <= 0;
        cyc(4);
        bus_read(0, code & 12'h0FF, 12'h0FF);
        bus_read(1, {6'h00, ctrl[1:0], code[11:8]}, 12'h0FF);
        word_byte_select <= 1;
        cyc(4);
        bus_read(0, code, 12'hFFF);
        $display("test conversion %h done", ctrl);
    endtask : conv
    // Control register writes: word, both bytes, refused
    task automatic t_writes;
        check(control_value, 12'h000);
        bus_write(12'hA01, 0);
        check(control_value, 12'hA01);
        word_byte_select <= 0;
        cyc(4);
        bus_write(12'h103, 0);
        check(control_value, 12'h301);
        bus_write(12'h042, 0);
        check(control_value, 12'h342);
        word_byte_select <= 1;
        cyc(4);
        bus_write(12'h7FF, 1);
        check(control_value, 12'h342);
        $display("test writes done");
    endtask : t_writes
    // Auto shutdown: sleeps after a conversion, wakes on rising start
    task automatic t_auto;
        conv(12'h009);
        check({11'h0, powered_up}, 12'h000);
        convert_start_n <= 0;
        cyc(6);
        check({11'h0, busy}, 12'h000);
        convert_start_n <= 1;
        cyc(6);
        check({11'h0, powered_up}, 12'h001);
        // Auto standby sleeps too; full shutdown ignores start and wake
        conv(12'h00E);
        check({11'h0, powered_up}, 12'h000);
        bus_write(12'h004, 0);
        convert_start_n <= 0;
        cyc(6);
        convert_start_n <= 1;
        cyc(6);
        check({10'h000, busy, powered_up}, 12'h000);
        $display("test auto power done");
    endtask : t_auto
    task automatic final_report;
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : final_report
    // Main sequence
    initial begin
        cyc(16);
        reset <= 0;
        cyc(2);
        t_writes();
        for (int c = 0; c < 4; c++) conv(12'(c));
        t_auto();
        final_report();
    end
    // Watchdog
    initial begin
        #100us;
        n_mismatch++;
        final_report();
    end
endmodule : tb_top
bind pahi_port pahi_port_properties #(.TAIL_CYC(TAIL_CYC)) u_chk (.clock(clock), .reset(reset),
    .convert_start_n(convert_start_n), .chip_select_n(chip_select_n), .read_strobe_n(read_strobe_n),
    .word_byte_select(word_byte_select), .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
    .busy(busy), .hold_mode(hold_mode), .active_channel(active_channel), .control_value(control_value));
